// ### verilog/epb_pkg.sv
// constants and types shared by the external port bus interface
package epb_pkg;

    localparam int          EPB_ADDR_W    = 32;
    localparam int          EPB_DATA_W    = 64;
    localparam int          EPB_HALF_W    = 32;
    localparam int          EPB_BANKS     = 4;
    localparam int          EPB_CFG_W     = 4;
    localparam int          EPB_ID_W      = 3;
    // first address of external memory, bank 0
    localparam logic [31:0] EPB_EXT_BASE  = 32'h0040_0000;
    // smallest bank is 2**EPB_BANK_SHIFT words; cfg adds to the shift
    localparam int          EPB_BANK_SHIFT = 13;
    // id bits [2:1] that switch the pin keepers on (pattern 00x)
    localparam logic [1:0]  EPB_KEEP_ID   = 2'b00;
    localparam logic [3:0]  EPB_SEL_IDLE  = 4'hF;
    localparam logic [31:0] EPB_ADDR_PARK = 32'h0000_0000;
    localparam logic [63:0] EPB_DATA_RST  = 64'h0000_0000_0000_0000;
    localparam int          EPB_SYNC_STAGES = 2;

    typedef enum logic [0:0] {
        EPB_ST_IDLE,
        EPB_ST_ACCESS
    } epb_state_e;

endpackage

// ### verilog/epb_keeper.sv
// bus-hold keeper for a group of three-state pins
`timescale 1ns/100ps
module epb_keeper #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    // control
    input  wire logic             keep_en,
    input  wire logic             drv_oe,
    // resolved pin level
    input  wire logic [WIDTH-1:0] pin_i,
    // hold drive, weaker than any real driver
    output logic      [WIDTH-1:0] hold_o,
    output logic                  hold_oe
);
    // refused while elaborating, not at run time
    if (WIDTH < 1)
    begin
        $error("keeper width must be at least one");
    end

    // remembers the last level seen so an undriven bus reads it back
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            hold_o <= '0;
        else
            hold_o <= pin_i;
    end

    assign hold_oe = keep_en & ~drv_oe;

endmodule

// ### verilog/epb_port.sv
// external port bus interface: bus master and internal memory slave
`timescale 1ns/100ps
module epb_port
    import epb_pkg::*;
(
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst_b,
    // configuration and status
    input  wire logic [EPB_ID_W-1:0]   processor_id_bits,
    input  wire logic [EPB_CFG_W-1:0]  bank_size_cfg,
    input  wire logic                  sync_access_mode,
    input  wire logic                  bus_grant_async,
    input  wire logic                  bus_suspend_tristate_n,
    input  wire logic                  ext_ack,
    // core master requests
    input  wire logic                  mreq_valid,
    output logic                       mreq_ready,
    input  wire logic                  mreq_write,
    input  wire logic                  mreq_low,
    input  wire logic                  mreq_high,
    input  wire logic                  mreq_last,
    input  wire logic [EPB_ADDR_W-1:0] mreq_addr,
    input  wire logic [EPB_DATA_W-1:0] mreq_wdata,
    output logic                       mrsp_valid,
    output logic      [EPB_DATA_W-1:0] mrsp_rdata,
    // internal memory, reached by an outside master
    output logic                       mem_rd_low,
    output logic                       mem_rd_high,
    output logic                       mem_wr_low,
    output logic                       mem_wr_high,
    output logic      [EPB_ADDR_W-1:0] mem_addr,
    output logic      [EPB_DATA_W-1:0] mem_wdata,
    input  wire logic [EPB_DATA_W-1:0] mem_rdata,
    // address bus
    input  wire logic [EPB_ADDR_W-1:0] ext_addr_bus_i,
    output logic      [EPB_ADDR_W-1:0] ext_addr_bus_o,
    output logic                       ext_addr_bus_oe,
    output logic      [EPB_ADDR_W-1:0] addr_hold_o,
    output logic                       addr_hold_oe,
    // data bus
    input  wire logic [EPB_DATA_W-1:0] ext_data_bus_i,
    output logic      [EPB_DATA_W-1:0] ext_data_bus_o,
    output logic                       ext_data_bus_oe,
    output logic      [EPB_DATA_W-1:0] data_hold_o,
    output logic                       data_hold_oe,
    // bank selects
    output logic      [EPB_BANKS-1:0]  bank_select_n_o,
    output logic                       bank_select_n_oe,
    // strobes
    input  wire logic                  read_low_strobe_n_i,
    input  wire logic                  read_high_strobe_n_i,
    input  wire logic                  write_low_strobe_n_i,
    input  wire logic                  write_high_strobe_n_i,
    output logic                       read_low_strobe_n_o,
    output logic                       read_high_strobe_n_o,
    output logic                       write_low_strobe_n_o,
    output logic                       write_high_strobe_n_o,
    output logic                       strobe_oe,
    // burst indicator
    input  wire logic                  burst_sequential_i,
    output logic                       burst_sequential_o,
    output logic                       burst_sequential_oe,
    output logic                       burst_hold_o,
    output logic                       burst_hold_oe
);

////////////////////////////////////////////////////////////////////////////
    function automatic logic [EPB_BANKS-1:0] bank_decode(
        input logic [EPB_ADDR_W-1:0] addr,
        input logic [EPB_CFG_W-1:0]  size_cfg
    );
        logic [EPB_ADDR_W-1:0] offs;
        logic [EPB_ADDR_W-1:0] idx;
        offs = addr - EPB_EXT_BASE;
        idx  = offs >> (EPB_BANK_SHIFT + int'(size_cfg));
        bank_decode = EPB_SEL_IDLE;
        if (addr >= EPB_EXT_BASE && idx < EPB_ADDR_W'(EPB_BANKS))
            bank_decode[idx[1:0]] = 1'b0;
    endfunction

////////////////////////////////////////////////////////////////////////////
    logic                  grant_meta_r;
    logic                  master_r;
    epb_state_e            state_r;
    logic [EPB_ADDR_W-1:0] addr_r;
    logic [EPB_BANKS-1:0]  sel_r;
    logic                  rd_lo_r;
    logic                  rd_hi_r;
    logic                  wr_lo_r;
    logic                  wr_hi_r;
    logic                  write_r;
    logic                  last_r;
    logic                  burst_o_r;
    logic                  in_burst_r;
    logic [EPB_DATA_W-1:0] data_o_r;
    logic [EPB_ADDR_W-1:0] slv_cnt_r;
    logic                  slv_burst_r;
    logic                  start;
    logic                  beat_done;
    logic                  drive_ok;
    logic                  slv_read;
    logic                  slv_write;
    logic                  keep_en;

    // grant may change at any time, so it passes two flops first
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            grant_meta_r <= 1'b0;
            master_r     <= 1'b0;
        end
        else
        begin
            grant_meta_r <= bus_grant_async;
            master_r     <= grant_meta_r;
        end
    end

    assign drive_ok  = master_r & bus_suspend_tristate_n;
    assign start     = (state_r == EPB_ST_IDLE) & mreq_valid & drive_ok;
    assign beat_done = (state_r == EPB_ST_ACCESS) & ext_ack;
    assign mreq_ready = start;

////////////////////////////////////////////////////////////////////////////
    // master access sequencing
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            state_r <= EPB_ST_IDLE;
        else
        begin
            unique case (state_r)
                EPB_ST_IDLE:
                    if (start)
                        state_r <= EPB_ST_ACCESS;
                EPB_ST_ACCESS:
                    if (ext_ack)
                        state_r <= EPB_ST_IDLE;
            endcase
        end
    end

    // address and selects; in sync mode burst beats keep the first address on the bus
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            addr_r <= EPB_ADDR_PARK;
            sel_r  <= EPB_SEL_IDLE;
        end
        else if (start)
        begin
            if (!in_burst_r)
                addr_r <= mreq_addr;
            sel_r <= bank_decode(mreq_addr, bank_size_cfg);
        end
        else if (beat_done)
        begin
            sel_r <= EPB_SEL_IDLE;
            if (!sync_access_mode)
                addr_r <= EPB_ADDR_PARK;
        end
    end

    // strobes for the requested word halves
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_lo_r <= 1'b0;
            rd_hi_r <= 1'b0;
            wr_lo_r <= 1'b0;
            wr_hi_r <= 1'b0;
            write_r <= 1'b0;
            last_r  <= 1'b0;
        end
        else if (start)
        begin
            rd_lo_r <= ~mreq_write & mreq_low;
            rd_hi_r <= ~mreq_write & mreq_high;
            wr_lo_r <= mreq_write & mreq_low;
            wr_hi_r <= mreq_write & mreq_high;
            write_r <= mreq_write;
            last_r  <= mreq_last;
        end
        else if (beat_done)
        begin
            rd_lo_r <= 1'b0;
            rd_hi_r <= 1'b0;
            wr_lo_r <= 1'b0;
            wr_hi_r <= 1'b0;
        end
    end

    // burst indicator low on the first beat and on the final one
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            in_burst_r <= 1'b0;
            burst_o_r  <= 1'b0;
        end
        else
        begin
            if (start)
                burst_o_r <= in_burst_r & ~mreq_last;
            if (beat_done)
                in_burst_r <= ~last_r;
        end
    end

    // write data toward the bus, or internal data toward an outside reader
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            data_o_r <= EPB_DATA_RST;
        else if (start && mreq_write)
            data_o_r <= mreq_wdata;
        else if (slv_read)
            data_o_r <= mem_rdata;
    end

    // read data captured on acknowledge
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mrsp_valid <= 1'b0;
            mrsp_rdata <= EPB_DATA_RST;
        end
        else
        begin
            mrsp_valid <= beat_done & ~write_r;
            if (beat_done && !write_r)
                mrsp_rdata <= ext_data_bus_i;
        end
    end

////////////////////////////////////////////////////////////////////////////
    // slave side: outside master reaches internal memory
    assign slv_read  = ~master_r
                     & (~read_low_strobe_n_i | ~read_high_strobe_n_i);
    assign slv_write = ~master_r
                     & (~write_low_strobe_n_i | ~write_high_strobe_n_i);

    // counter takes over from the first address while the burst lasts
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            slv_cnt_r   <= EPB_ADDR_PARK;
            slv_burst_r <= 1'b0;
        end
        else if (slv_read || slv_write)
        begin
            slv_burst_r <= burst_sequential_i;
            if (burst_sequential_i)
                slv_cnt_r <= mem_addr + EPB_ADDR_W'(1);
        end
        else
            slv_burst_r <= 1'b0;
    end

    assign mem_addr    = slv_burst_r ? slv_cnt_r : ext_addr_bus_i;
    assign mem_rd_low  = ~master_r & ~read_low_strobe_n_i;
    assign mem_rd_high = ~master_r & ~read_high_strobe_n_i;
    assign mem_wr_low  = ~master_r & ~write_low_strobe_n_i;
    assign mem_wr_high = ~master_r & ~write_high_strobe_n_i;
    assign mem_wdata   = ext_data_bus_i;

////////////////////////////////////////////////////////////////////////////
    // pin drive; strobes never driven by a non-master
    assign ext_addr_bus_o        = addr_r;
    assign ext_addr_bus_oe       = drive_ok;
    assign bank_select_n_o       = sel_r;
    assign bank_select_n_oe      = drive_ok;
    assign read_low_strobe_n_o   = ~rd_lo_r;
    assign read_high_strobe_n_o  = ~rd_hi_r;
    assign write_low_strobe_n_o  = ~wr_lo_r;
    assign write_high_strobe_n_o = ~wr_hi_r;
    assign strobe_oe             = drive_ok;
    assign burst_sequential_o    = burst_o_r;
    assign burst_sequential_oe   = drive_ok;
    assign ext_data_bus_o        = data_o_r;
    // outside reader is served even while not master
    assign ext_data_bus_oe = bus_suspend_tristate_n
                           & ((drive_ok & write_r) | slv_read);

    assign keep_en = (processor_id_bits[2:1] == EPB_KEEP_ID);

    epb_keeper #(.WIDTH(EPB_ADDR_W)) u_keep_addr (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .keep_en  (keep_en),
        .drv_oe   (ext_addr_bus_oe),
        .pin_i    (ext_addr_bus_i),
        .hold_o   (addr_hold_o),
        .hold_oe  (addr_hold_oe)
    );

    epb_keeper #(.WIDTH(EPB_DATA_W)) u_keep_data (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .keep_en  (keep_en),
        .drv_oe   (ext_data_bus_oe),
        .pin_i    (ext_data_bus_i),
        .hold_o   (data_hold_o),
        .hold_oe  (data_hold_oe)
    );

    epb_keeper #(.WIDTH(1)) u_keep_burst (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .keep_en  (keep_en),
        .drv_oe   (burst_sequential_oe),
        .pin_i    (burst_sequential_i),
        .hold_o   (burst_hold_o),
        .hold_oe  (burst_hold_oe)
    );

////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    grant_sync_a: assert property ($past(rst_b, 2) |->
        master_r == $past(bus_grant_async, 2))
        else $error("grant not synchronised in two stages");
    suspend_hiz_a: assert property (!bus_suspend_tristate_n |->
        !ext_addr_bus_oe && !bank_select_n_oe && !strobe_oe
        && !ext_data_bus_oe)
        else $error("bus driven during suspend");
    slave_hiz_a: assert property (!master_r |->
        !strobe_oe && !ext_addr_bus_oe && !burst_sequential_oe)
        else $error("non-master drives strobes or address");
    start_addr_a: assert property (start && !in_burst_r |=>
        ext_addr_bus_o == $past(mreq_addr))
        else $error("address not driven for access");
    start_sel_a: assert property (start |=>
        bank_select_n_o == bank_decode($past(mreq_addr),
                                       $past(bank_size_cfg)))
        else $error("bank select does not match address");
    async_sel_a: assert property (beat_done && !sync_access_mode |=>
        bank_select_n_o == EPB_SEL_IDLE && ext_addr_bus_o == EPB_ADDR_PARK)
        else $error("select and address did not change together");
    sync_sel_a: assert property (beat_done && sync_access_mode |=>
        bank_select_n_o == EPB_SEL_IDLE && $stable(ext_addr_bus_o))
        else $error("select not removed after acknowledge");
    read_strobe_a: assert property (start && !mreq_write && mreq_low |=>
        !read_low_strobe_n_o && write_low_strobe_n_o)
        else $error("low read strobe missing");
    write_strobe_a: assert property (start && mreq_write && mreq_high |=>
        !write_high_strobe_n_o && read_high_strobe_n_o)
        else $error("high write strobe missing");
    write_data_a: assert property (start && mreq_write |=>
        ext_data_bus_o == $past(mreq_wdata) && ext_data_bus_oe)
        else $error("write data not driven");
    burst_hold_a: assert property (start && in_burst_r |=>
        $stable(ext_addr_bus_o))
        else $error("master moved address inside burst");
    burst_first_a: assert property (start && (!in_burst_r || mreq_last)
        |=> !burst_sequential_o)
        else $error("burst raised on first or last beat");
    idle_quiet_a: assert property (master_r && state_r == EPB_ST_IDLE
        && $past(state_r) == EPB_ST_IDLE |->
        bank_select_n_o == EPB_SEL_IDLE && read_low_strobe_n_o
        && read_high_strobe_n_o && write_low_strobe_n_o
        && write_high_strobe_n_o)
        else $error("idle master left a select or strobe active");
    slave_inc_a: assert property ((slv_read || slv_write)
        && burst_sequential_i ##1 (slv_read || slv_write) |->
        mem_addr == $past(mem_addr) + EPB_ADDR_W'(1))
        else $error("slave burst address did not advance");

    burst_read_c: cover property (start && !mreq_write ##[1:8] beat_done
        ##[1:8] start && in_burst_r);
    sync_write_c: cover property (sync_access_mode && start && mreq_write
        ##[1:8] beat_done);
    slave_burst_c: cover property (slv_read && burst_sequential_i
        ##1 slv_read && burst_sequential_i ##1 slv_read);
    suspend_c: cover property (mreq_valid && master_r
        && !bus_suspend_tristate_n);

endmodule

// ### testbench/epb_mem_model.sv
// external memory model answering the port's master accesses
`timescale 1ns/100ps
module epb_mem_model
    import epb_pkg::*;
(
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst_b,
    // wait states before acknowledge
    input  wire logic [3:0]            wait_cnt,
    // bus as seen at the pins
    input  wire logic [EPB_BANKS-1:0]  sel_n,
    input  wire logic                  rd_n,
    input  wire logic                  wr_n,
    input  wire logic [EPB_ADDR_W-1:0] addr,
    // answer
    output logic                       ack,
    output logic      [EPB_DATA_W-1:0] rdata,
    output logic                       rdata_oe
);
    logic [3:0] cnt_r;
    logic       busy;

    assign busy = ~&sel_n & ~(rd_n & wr_n);
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            cnt_r <= 4'h0;
        else
            cnt_r <= busy ? cnt_r + 4'h1 : 4'h0;
    end
    // ack only inside an access, so a stuck select never completes
    assign ack      = busy & (cnt_r == wait_cnt);
    // data tied to the address so a wrong half or address shows up
    assign rdata    = {~addr, addr};
    assign rdata_oe = ~&sel_n & ~rd_n;
endmodule

// ### testbench/external_port_bus_interface_tb.sv
// self-checking bench for the external port bus interface
`timescale 1ns/100ps
module external_port_bus_interface_tb
    import epb_pkg::*;
;
    typedef struct packed {
        logic [4:0]  flg;
        logic [3:0]  cfg;
        logic [3:0]  wt;
        logic [31:0] addr;
        logic [3:0]  sel;
    } epb_row_s;

    logic core_clk, rst_b, sync_access_mode, bus_grant_async, ext_ack;
    logic bus_suspend_tristate_n, mreq_valid, mreq_ready, mreq_write;
    logic mreq_low, mreq_high, mreq_last, mrsp_valid, mem_rd_low;
    logic mem_rd_high, mem_wr_low, mem_wr_high, strobe_oe, flip_r;
    logic ext_addr_bus_oe, addr_hold_oe, ext_data_bus_oe, data_hold_oe;
    logic bank_select_n_oe, burst_sequential_i, burst_sequential_o;
    logic burst_sequential_oe, burst_hold_o, burst_hold_oe;
    logic read_low_strobe_n_i, read_high_strobe_n_i, write_low_strobe_n_i;
    logic write_high_strobe_n_i, read_low_strobe_n_o, read_high_strobe_n_o;
    logic write_low_strobe_n_o, write_high_strobe_n_o;
    logic [2:0]  processor_id_bits;
    logic [3:0]  bank_size_cfg, bank_select_n_o, tb_stb_n, wait_cnt;
    logic [31:0] mreq_addr, mem_addr, ext_addr_bus_i, ext_addr_bus_o;
    logic [31:0] addr_hold_o, tb_addr, first_a;
    logic [63:0] mreq_wdata, mrsp_rdata, mem_wdata, mem_rdata, tb_data;
    logic [63:0] ext_data_bus_i, ext_data_bus_o, data_hold_o, mdl_rdata;
    logic        tb_addr_oe, tb_data_oe, tb_burst, mdl_oe, prev_last;
    int          error_cnt, checked;
    // flags: sync, write, low, high, last
    epb_row_s rows [9] = '{
        {5'h05, 4'h0, 4'h0, 32'h0040_0000, 4'hE},
        {5'h0B, 4'h0, 4'h2, 32'h0040_2004, 4'hD},
        {5'h17, 4'h0, 4'h1, 32'h0040_4010, 4'hB},
        {5'h1F, 4'h0, 4'h3, 32'h0040_7FFF, 4'h7},
        {5'h16, 4'h0, 4'h1, 32'h0040_2100, 4'hD},
        {5'h16, 4'h0, 4'h0, 32'h0040_2101, 4'hD},
        {5'h17, 4'h0, 4'h2, 32'h0040_2102, 4'hD},
        {5'h0D, 4'h1, 4'h0, 32'h0040_4000, 4'hD},
        {5'h03, 4'h2, 4'h1, 32'h0041_8000, 4'h7}};

    ////////////////////////////////////////////////////////////////////
    // pins: a released wire toggles each cycle instead of keeping data
    always @(posedge core_clk or negedge rst_b)
        flip_r <= !rst_b ? 1'h0 : ~flip_r;
    assign ext_addr_bus_i = ext_addr_bus_oe ? ext_addr_bus_o : tb_addr_oe ?
        tb_addr : addr_hold_oe ? addr_hold_o : {32{flip_r}};
    assign ext_data_bus_i = ext_data_bus_oe ? ext_data_bus_o : mdl_oe ?
        mdl_rdata : tb_data_oe ? tb_data : data_hold_oe ? data_hold_o :
        {64{flip_r}};
    // no function call here: a continuous assign would miss its inputs
    assign {write_high_strobe_n_i, write_low_strobe_n_i, read_high_strobe_n_i,
        read_low_strobe_n_i} = strobe_oe ? {write_high_strobe_n_o,
        write_low_strobe_n_o, read_high_strobe_n_o, read_low_strobe_n_o} :
        tb_stb_n;
    // the outside master drives burst while it drives a strobe
    assign burst_sequential_i = burst_sequential_oe ? burst_sequential_o :
        ~&tb_stb_n ? tb_burst : burst_hold_oe & burst_hold_o;
    assign mem_rdata = {mem_addr, ~mem_addr};

    epb_port u_dut (.*);
    epb_mem_model u_mem (.core_clk, .rst_b, .wait_cnt,
        .sel_n(bank_select_n_oe ? bank_select_n_o : 4'hF),
        .rd_n(read_low_strobe_n_i & read_high_strobe_n_i),
        .wr_n(write_low_strobe_n_i & write_high_strobe_n_i),
        .addr(ext_addr_bus_i), .ack(ext_ack), .rdata(mdl_rdata),
        .rdata_oe(mdl_oe));

    ////////////////////////////////////////////////////////////////////
    function automatic logic [3:0] strb();
        return {write_high_strobe_n_o, write_low_strobe_n_o,
            read_high_strobe_n_o, read_low_strobe_n_o};
    endfunction

    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("counts: %0d checked, %0d mismatches", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic master_op(input epb_row_s r);
        logic sy, wr, lo, hi, la;
        {sy, wr, lo, hi, la} = r.flg;
        if (prev_last)
            first_a = r.addr;
        @(posedge core_clk);
        sync_access_mode <= sy;
        bank_size_cfg    <= r.cfg;
        wait_cnt         <= r.wt;
        mreq_valid       <= 1'h1;
        {mreq_write, mreq_low, mreq_high, mreq_last} <= {wr, lo, hi, la};
        mreq_addr        <= r.addr;
        mreq_wdata       <= {r.addr, ~r.addr};
        repeat (20)
        begin
            @(negedge core_clk);
            if (mreq_ready === 1'h1)
                break;
        end
        chk(mreq_ready, 1'h1);
        @(posedge core_clk);
        mreq_valid <= 1'h0;
        @(negedge core_clk);
        chk({ext_addr_bus_oe, ext_addr_bus_o}, {1'h1, first_a});
        chk(bank_select_n_o, r.sel);
        chk(strb(),
            4'(~{wr & hi, wr & lo, ~wr & hi, ~wr & lo}));
        chk(burst_sequential_o, 1'(~prev_last & ~la));
        if (wr)
            chk(ext_data_bus_o, {r.addr, ~r.addr});
        repeat (20)
        begin
            if (ext_ack === 1'h1)
                break;
            @(negedge core_clk);
        end
        chk(ext_ack, 1'h1);
        chk(bank_select_n_o, r.sel);
        @(negedge core_clk);
        chk({bank_select_n_o, strb()}, 8'hFF);
        if (!sy)
            chk(ext_addr_bus_o, EPB_ADDR_PARK);
        if (!wr)
            chk({mrsp_valid, mrsp_rdata & {{32{hi}}, {32{lo}}}},
                {1'h1, {~first_a, first_a} & {{32{hi}}, {32{lo}}}});
        prev_last = la;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        core_clk = 1'h0;
        forever
            #20 core_clk = ~core_clk;
    end

    initial
    begin
        repeat (2500) @(posedge core_clk);
        error_cnt++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        end_of_test();
    end

    initial
    begin
        {rst_b, sync_access_mode, mreq_valid, tb_addr_oe} = 4'h0;
        {mreq_write, mreq_low, mreq_high, mreq_last, tb_data_oe} = 5'h0;
        {bus_grant_async, bus_suspend_tristate_n, prev_last} = 3'h7;
        {processor_id_bits, bank_size_cfg, wait_cnt, tb_stb_n} = 15'h00F;
        {mreq_addr, tb_addr, tb_data, mreq_wdata} = 192'h0;
        tb_burst = 1'h0;
        repeat (8) @(posedge core_clk);
        rst_b <= 1'h1;
        repeat (4) @(negedge core_clk);
        chk({strobe_oe, bank_select_n_o, strb()}, 9'h1FF);
        foreach (rows[i])
            master_op(rows[i]);
        $display("test done: master rows");
        @(posedge core_clk);
        bus_suspend_tristate_n <= 1'h0;
        mreq_valid             <= 1'h1;
        @(negedge core_clk);
        chk({ext_addr_bus_oe, ext_data_bus_oe, strobe_oe, bank_select_n_oe,
            burst_sequential_oe, mreq_ready}, 6'h0);
        bus_suspend_tristate_n <= 1'h1;
        mreq_valid             <= 1'h0;
        bus_grant_async        <= 1'h0;
        repeat (3) @(negedge core_clk);
        chk({ext_addr_bus_oe, strobe_oe, bank_select_n_oe}, 3'h0);
        $display("test done: suspend and slave release");
        @(posedge core_clk);
        {tb_addr_oe, tb_burst, tb_addr, tb_stb_n} <= {2'h3, 32'h1230, 4'hE};
        @(negedge core_clk);
        chk({mem_rd_low, mem_rd_high, ext_data_bus_oe, mem_addr},
            {3'h5, 32'h1230});
        @(posedge core_clk);
        tb_addr_oe <= 1'h0;
        @(negedge core_clk);
        chk({mem_addr, ext_data_bus_o}, {32'h1231, 32'h1230, ~32'h1230});
        @(posedge core_clk);
        tb_burst <= 1'h0;
        @(negedge core_clk);
        chk({mem_addr, addr_hold_oe, addr_hold_o}, {32'h1232, 1'h1, 32'h1230});
        @(posedge core_clk);
        {processor_id_bits, tb_stb_n} <= {3'h2, 4'hF};
        @(negedge core_clk);
        chk({addr_hold_oe, mem_addr}, {1'h0, ext_addr_bus_i});
        @(posedge core_clk);
        {tb_addr_oe, tb_addr, tb_stb_n} <= {1'h1, 32'h2468, 4'h7};
        {tb_data_oe, tb_data} <= {1'h1, 64'h1357_9BDF_0246_8ACE};
        @(negedge core_clk);
        chk({mem_wr_high, mem_wr_low, ext_data_bus_oe, mem_addr, mem_wdata},
            {3'h4, 32'h2468, 64'h1357_9BDF_0246_8ACE});
        $display("test done: slave access");
        @(posedge core_clk);
        {tb_stb_n, tb_data_oe, tb_addr_oe, bus_grant_async} <= 7'h79;
        rst_b <= 1'h0;
        @(negedge core_clk);
        chk({bank_select_n_o, strb(), strobe_oe, mrsp_valid}, 10'h3FC);
        repeat (8) @(posedge core_clk);
        rst_b <= 1'h1;
        @(posedge core_clk);
        @(negedge core_clk);
        chk(strobe_oe, 1'h0);
        @(negedge core_clk);
        chk(strobe_oe, 1'h1);
        $display("test done: reset and grant sync");
        end_of_test();
    end
endmodule
